// ---- src/clk_sel_pkg.sv ----
package clk_sel_pkg;
	// ------------------------------------------------------------
	// switchover timing and reset values
	// ------------------------------------------------------------
	localparam int         SWITCH_CYC_MAX = 3;
	localparam int         CNT_W          = 2;
	localparam logic [1:0] CNT_RST        = 2'h0;
	localparam logic       SRC_RST        = 1'h1;
	localparam logic       EN_RST         = 1'h0;
	localparam logic       OUT_RST        = 1'h0;
	localparam int         SYNC_W         = 6;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DISABLE_OLD,
		ST_ENABLE_NEW
	} sw_state_t;
endpackage

// ---- src/glitchless_clock_select_fanout.sv ----
// Overview of operation
// - choice high routes first clock input, low routes second clock input.
// - on choice change, force outputs low at the first low level of the old clock.
// - then hold low until one new-clock rising edge, then run from new input at its next low.
// - force-switch rising edge completes selection at once, even with dead old clock.
// - hold control low lets outputs toggle once a switchover or force-switch has enabled them after reset; high forces outputs to idle level.
// - idle level high: true high, complement low; low: true low, complement high.
// - sleep_n low: stop switching and pull true and complement outputs high.
// - the one selected clock drives both output pairs, true and complement.
module glitchless_clock_select_fanout
	import clk_sel_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic arst_n_in,
	input  wire logic clk_in_one_in,
	input  wire logic clk_in_two_in,
	input  wire logic clk_choice_in,
	input  wire logic force_switch_in,
	input  wire logic gate_n_in,
	input  wire logic idle_level_in,
	input  wire logic sleep_n_in,
	output logic      clk_out_one_out,
	output logic      clk_out_one_n_out,
	output logic      clk_out_two_out,
	output logic      clk_out_two_n_out,
	output logic      switching_out
);
	import clk_sel_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (SWITCH_CYC_MAX >= (1 << CNT_W)) begin : g_cnt_chk
		$error("switch counter too narrow for the cycle bound");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] pins_s;
	logic              one_s;
	logic              two_s;
	logic              choice_s;
	logic              force_s;
	logic              gate_n_s;
	logic              idle_s;
	logic              sleep_n_s;

	pin_sync #(
		.W (SYNC_W)
	) u_sync (
		.core_clk_in (core_clk_in),
		.arst_n_in   (arst_n_in),
		.pin_in      ({clk_in_one_in, clk_in_two_in, clk_choice_in,
		               force_switch_in, gate_n_in, idle_level_in}),
		.sync_out    (pins_s)
	);

	logic [1:0] sleep_meta_r;

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sleep_meta_r <= 2'h0;
		end else begin
			sleep_meta_r <= {sleep_meta_r[0], sleep_n_in};
		end
	end

	assign {one_s, two_s, choice_s, force_s, gate_n_s, idle_s} = pins_s;
	assign sleep_n_s = sleep_meta_r[1];

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic pick(input logic src, input logic a, input logic b);
		pick = src ? a : b;
	endfunction

	// ------------------------------------------------------------
	// switchover state machine
	// ------------------------------------------------------------
	sw_state_t        state_r;
	sw_state_t        state_nxt;
	logic             src_r;
	logic             src_nxt;
	logic             en_r;
	logic             en_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             one_d_r;
	logic             two_d_r;
	logic             force_d_r;
	logic             old_clk;
	logic             old_d;
	logic             new_clk;
	logic             new_d;
	logic             force_rise;

	assign old_clk    = pick(src_r, one_s, two_s);
	assign old_d      = pick(src_r, one_d_r, two_d_r);
	assign new_clk    = pick(src_r, one_s, two_s);
	assign new_d      = pick(src_r, one_d_r, two_d_r);
	assign force_rise = force_s && !force_d_r;

	always_comb begin
		state_nxt = state_r;
		src_nxt   = src_r;
		en_nxt    = en_r;
		cnt_nxt   = cnt_r;
		if (!sleep_n_s) begin
			state_nxt = state_r;
		end else if (force_rise) begin
			state_nxt = ST_RUN;
			src_nxt   = choice_s;
			en_nxt    = 1'h1;
			cnt_nxt   = CNT_RST;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (choice_s != src_r) begin
						state_nxt = ST_DISABLE_OLD;
						cnt_nxt   = CNT_RST;
					end
				end
				ST_DISABLE_OLD: begin
					if (!old_clk) begin
						en_nxt    = 1'h0;
						src_nxt   = choice_s;
						state_nxt = ST_ENABLE_NEW;
						cnt_nxt   = CNT_RST;
					end
				end
				ST_ENABLE_NEW: begin
					if (new_clk && !new_d && int'(cnt_r) < SWITCH_CYC_MAX) begin
						cnt_nxt = cnt_r + CNT_W'(1);
					end
					if (!new_clk && cnt_r != CNT_RST) begin
						en_nxt    = 1'h1;
						state_nxt = ST_RUN;
					end
				end
				default: begin
					state_nxt = ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r   <= ST_RUN;
			src_r     <= SRC_RST;
			en_r      <= EN_RST;
			cnt_r     <= CNT_RST;
			one_d_r   <= 1'h0;
			two_d_r   <= 1'h0;
			force_d_r <= 1'h0;
		end else begin
			state_r   <= state_nxt;
			src_r     <= src_nxt;
			en_r      <= en_nxt;
			cnt_r     <= cnt_nxt;
			one_d_r   <= one_s;
			two_d_r   <= two_s;
			force_d_r <= force_s;
		end
	end

	// ------------------------------------------------------------
	// switchover status
	// ------------------------------------------------------------
	logic busy_r;
	logic busy_nxt;

	assign busy_nxt = state_nxt != ST_RUN;

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_r <= 1'h0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	// ------------------------------------------------------------
	// output gating and fanout
	// ------------------------------------------------------------
	logic q_r;
	logic q_nxt;
	logic qn_r;
	logic qn_nxt;
	logic run_clk;

	assign run_clk = pick(src_r, one_s, two_s) && en_r;

	always_comb begin
		if (!sleep_n_s) begin
			q_nxt  = 1'h1;
			qn_nxt = 1'h1;
		end else if (gate_n_s) begin
			q_nxt  = idle_s;
			qn_nxt = !idle_s;
		end else begin
			q_nxt  = run_clk;
			qn_nxt = !run_clk;
		end
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			q_r  <= OUT_RST;
			qn_r <= !OUT_RST;
		end else begin
			q_r  <= q_nxt;
			qn_r <= qn_nxt;
		end
	end

	assign clk_out_one_out   = q_r;
	assign clk_out_one_n_out = qn_r;
	assign clk_out_two_out   = q_r;
	assign clk_out_two_n_out = qn_r;
	assign switching_out     = busy_r;
endmodule

// ---- src/pin_sync.sv ----
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk_in,
	input  wire logic         arst_n_in,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] sync_out
);
	// ------------------------------------------------------------
	// two-stage synchroniser
	// ------------------------------------------------------------
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	if (W < 1) begin : g_w_chk
		$error("pin_sync: W must be at least 1");
	end

	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule

// ---- verif/clk_sel_monitor.sv ----
module clk_sel_monitor (
	input wire logic core_clk_in,
	input wire logic arst_n_in,
	input wire logic clk_in_one_in,
	input wire logic clk_in_two_in,
	input wire logic clk_choice_in,
	input wire logic force_switch_in,
	input wire logic gate_n_in,
	input wire logic idle_level_in,
	input wire logic sleep_n_in,
	input wire logic clk_out_one_out,
	input wire logic clk_out_one_n_out,
	input wire logic clk_out_two_out,
	input wire logic clk_out_two_n_out,
	input wire logic switching_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] settle_r;
	always_ff @(posedge core_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			settle_r <= 3'h0;
		end else if (settle_r != 3'h7) begin
			settle_r <= settle_r + 3'h1;
		end
	end
	wire o  = clk_out_one_out;
	wire on = clk_out_one_n_out;
	wire sw = switching_out;
	wire h  = gate_n_in && sleep_n_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!arst_n_in || settle_r != 3'h7);
	a_pairs_equal: assert property (o == clk_out_two_out && on == clk_out_two_n_out)
		else $error("pairs");
	a_sleep_high: assert property (!sleep_n_in [*4] |-> o && on) else $error("sleep");
	a_hold_high: assert property ((h && idle_level_in) [*4] |-> o && !on)
		else $error("hold high");
	a_hold_low: assert property ((h && !idle_level_in) [*4] |-> !o && on)
		else $error("hold low");
	a_switch_start: assert property ($changed(clk_choice_in) && sleep_n_in && !force_switch_in
		|-> ##[1:4] sw) else $error("start");
	a_switch_end: assert property ($rose(sw) |-> ##[1:150] !sw) else $error("end");
	a_force_done: assert property ($rose(force_switch_in) && sw |-> ##[1:4] !sw)
		else $error("force");
	a_follow_src: assert property ((!sw && sleep_n_in && !gate_n_in && $stable(clk_choice_in))
		[*6] |-> o == (clk_choice_in ? $past(clk_in_one_in, 3) : $past(clk_in_two_in, 3)))
		else $error("follow");
	c_switch: cover property ($rose(sw));
	c_force: cover property ($rose(force_switch_in) && sw);
	c_sleep: cover property (!sleep_n_in [*4]);
endmodule
bind glitchless_clock_select_fanout clk_sel_monitor u_mon (
	.core_clk_in       (core_clk_in),
	.arst_n_in         (arst_n_in),
	.clk_in_one_in     (clk_in_one_in),
	.clk_in_two_in     (clk_in_two_in),
	.clk_choice_in     (clk_choice_in),
	.force_switch_in   (force_switch_in),
	.gate_n_in         (gate_n_in),
	.idle_level_in     (idle_level_in),
	.sleep_n_in        (sleep_n_in),
	.clk_out_one_out   (clk_out_one_out),
	.clk_out_one_n_out (clk_out_one_n_out),
	.clk_out_two_out   (clk_out_two_out),
	.clk_out_two_n_out (clk_out_two_n_out),
	.switching_out     (switching_out)
);

// ---- verif/clk_src_model.sv ----
module clk_src_model (
	input  wire logic run_one_in,
	output logic      clk_one_out,
	output logic      clk_two_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial clk_one_out = 1'h0;
	initial clk_two_out = 1'h0;
	// a stopped first source sticks high
	always #250 clk_one_out = run_one_in ? ~clk_one_out : 1'h1;
	always #350 clk_two_out = ~clk_two_out;
endmodule

// ---- verif/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_in, arst_n_in, clk_in_one_in, clk_in_two_in, clk_choice_in, run;
	logic force_switch_in, gate_n_in, idle_level_in, sleep_n_in, switching_out;
	logic clk_out_one_out, clk_out_one_n_out, clk_out_two_out, clk_out_two_n_out;
	int   mismatches, compares;
	wire  [3:0] q = {clk_out_one_out, clk_out_one_n_out, clk_out_two_out, clk_out_two_n_out};
	glitchless_clock_select_fanout u_dut (
		.core_clk_in       (core_clk_in),
		.arst_n_in         (arst_n_in),
		.clk_in_one_in     (clk_in_one_in),
		.clk_in_two_in     (clk_in_two_in),
		.clk_choice_in     (clk_choice_in),
		.force_switch_in   (force_switch_in),
		.gate_n_in         (gate_n_in),
		.idle_level_in     (idle_level_in),
		.sleep_n_in        (sleep_n_in),
		.clk_out_one_out   (clk_out_one_out),
		.clk_out_one_n_out (clk_out_one_n_out),
		.clk_out_two_out   (clk_out_two_out),
		.clk_out_two_n_out (clk_out_two_n_out),
		.switching_out     (switching_out)
	);
	clk_src_model u_src (.run_one_in(run), .clk_one_out(clk_in_one_in),
		.clk_two_out(clk_in_two_in));
	task chk(string n, logic [3:0] s, logic [3:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task final_report;
		if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(int n);
		repeat (n) @(posedge core_clk_in);
	endtask
	task t_force;
		force_switch_in <= 1'h1;
		cyc(6);
		chk("switching", {3'h0, switching_out}, 4'h0);
		force_switch_in <= 1'h0;
	endtask
	task t_hold;
		for (int i = 0; i < 2; i++) begin
			idle_level_in <= i[0];
			cyc(5);
			chk("hold", q, i ? 4'ha : 4'h5);
		end
	endtask
	task t_sleep;
		sleep_n_in <= 1'h0;
		cyc(5);
		chk("sleep", q, 4'hf);
		sleep_n_in <= 1'h1;
		cyc(5);
	endtask
	task automatic t_route(logic sel, int n);
		int   c;
		logic p;
		c = 0;
		p = 1'h1;
		gate_n_in <= 1'h0;
		clk_choice_in <= sel;
		cyc(5);
		for (int r = 0; switching_out && r < 150; r++) cyc(1);
		chk("switch done", {3'h0, switching_out}, 4'h0);
		repeat (n) begin
			@(negedge core_clk_in);
			c += int'(clk_out_one_out & !p);
			p = clk_out_one_out;
		end
		chk("rises", c[3:0], 4'ha);
		chk("pairs", q, {q[3], ~q[3], q[3], ~q[3]});
	endtask
	task t_dead;
		run <= 1'h0;
		cyc(12);
		clk_choice_in <= 1'h0;
		cyc(20);
		chk("stuck", {3'h0, switching_out}, 4'h1);
		force_switch_in <= 1'h1;
		cyc(5);
		force_switch_in <= 1'h0;
		t_route(1'h0, 141);
	endtask
	initial begin
		core_clk_in = 1'h0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	initial begin
		#200us;
		mismatches++;
		final_report;
	end
	initial begin
		arst_n_in = 1'h0;
		clk_choice_in = 1'h1;
		force_switch_in = 1'h0;
		gate_n_in = 1'h1;
		idle_level_in = 1'h0;
		sleep_n_in = 1'h1;
		run = 1'h1;
		cyc(3);
		arst_n_in <= 1'h1;
		cyc(5);
		t_force;
		t_hold;
		t_sleep;
		t_route(1'h0, 141);
		t_route(1'h1, 101);
		t_dead;
		final_report;
	end
endmodule
